//--- include/lcg_pkg.sv
package lcg_pkg;
  // register indices on the configuration port
  localparam logic [7:0] IDX_MEMCFG = 8'h00;
  localparam logic [7:0] IDX_WIDTH_AC = 8'h01;
  localparam logic [7:0] IDX_CG_LO = 8'h19;
  localparam logic [7:0] IDX_CG_HI = 8'h1A;
  // reset values
  localparam logic [7:0] MEMCFG_RESET = 8'h10;
  localparam logic [7:0] WIDTH_AC_RESET = 8'h00;
  localparam logic [7:0] CG_LO_RESET = 8'h00;
  localparam logic [7:0] CG_HI_RESET = 8'h00;
  // implemented bits; unimplemented ones read as zero
  localparam logic [7:0] MEMCFG_MASK = 8'h3F;
  localparam logic [7:0] WIDTH_AC_MASK = 8'h8F;
  // memory configuration field positions
  localparam int B_SRC = 0;
  localparam int B_RSV1 = 1;
  localparam int B_TALL = 2;
  localparam int B_DUAL = 3;
  localparam int B_ORG = 5;
  // glyph width / ac drive field positions
  localparam int B_AC = 7;
  localparam int W_LSB = 0;
  localparam int W_BITS = 4;
  // glyph geometry
  localparam int RAM_CHARS = 256;
  localparam logic [7:0] ROM_CHARS = 8'hA0;
  localparam logic [7:0] RAM_CHARS_WITH_ROM = 8'h40;
  localparam logic [4:0] ROM_ROWS = 5'h07;
  localparam logic [4:0] HEIGHT_SHORT = 5'h08;
  localparam logic [4:0] HEIGHT_TALL = 5'h10;
  localparam logic [4:0] SEG_PIX = 5'h08;
  localparam int AC_LINES = 16;
  localparam logic [1:0] BPP_1 = 2'h0;

  typedef struct packed {
    logic origin_comp_off;
    logic glyph_height_select;
    logic glyph_source_select;
    logic ac_inversion_select;
    logic [W_BITS-1:0] glyph_width_m1;
    logic [15:0] cg_start;
  } lcg_cfg_s;

  typedef struct packed {
    logic [$clog2(RAM_CHARS)-1:0] code;
    logic [3:0] row;
    logic seg;
    logic layer;
    logic graphics;
  } lcg_req_s;
endpackage : lcg_pkg

//--- rtl/lcg_ac_drive.sv
`timescale 1ns/1ps
module lcg_ac_drive import lcg_pkg::*; #(
  parameter int LINES = AC_LINES
) (
  // clock and reset
  input wire logic clk,
  input wire logic reset,
  // control
  input wire logic restart,
  input wire logic frame_mode,
  input wire logic line_stb,
  input wire logic frame_stb,
  // drive waveform
  output logic ac
);
  localparam int CW = (LINES < 2) ? 1 : $clog2(LINES);
  localparam logic [CW-1:0] LAST = CW'(LINES - 1);

  if (LINES < 2) begin : g_bad_lines
    $error("lcg_ac_drive: LINES must be at least 2");
  end

  logic [CW-1:0] cnt;

  always_ff @(posedge clk) begin
    if (reset || restart || frame_mode) begin
      cnt <= '0;
    end else if (line_stb) begin
      cnt <= (cnt == LAST) ? '0 : cnt + 1'b1;
    end
  end

  // frame mode toggles once a frame, so one full period spans two frames
  always_ff @(posedge clk) begin
    if (reset || restart) begin
      ac <= 1'b0;
    end else if (frame_mode ? frame_stb : (line_stb && cnt == LAST)) begin
      ac <= ~ac;
    end
  end

  property p_line_toggle;
    @(posedge clk) disable iff (reset)
    (line_stb && !frame_mode && !restart && cnt == LAST) |=> (ac != $past(ac));
  endproperty
  a_line_toggle: assert property (p_line_toggle) else $error("ac not toggled after line group");

  property p_line_hold;
    @(posedge clk) disable iff (reset)
    (!frame_mode && !restart && !(line_stb && cnt == LAST)) |=> $stable(ac);
  endproperty
  a_line_hold: assert property (p_line_hold) else $error("ac toggled inside line group");

  property p_frame_toggle;
    @(posedge clk) disable iff (reset)
    (frame_mode && frame_stb && !restart) |=> (ac != $past(ac));
  endproperty
  a_frame_toggle: assert property (p_frame_toggle) else $error("ac not toggled at frame");
endmodule : lcg_ac_drive

//--- rtl/lcg_char_config.sv
`timescale 1ns/1ps
// Summary of operation
// - with origin offset active, text glyphs appear one pixel row lower.
// - height select gives 8-row glyphs when clear, 16-row when set.
// - reserved bit 1 of memory configuration resets to zero.
// - source select takes glyphs from fixed ROM when clear, user RAM when set.
// - fixed ROM holds 160 unalterable glyphs of 5x7 pixels.
// - user RAM holds up to 256 glyphs at the two-register start address.
// - with ROM selected, user RAM is limited to 64 glyphs of 8x8.
// - while any user glyph RAM is in use, only 1 bpp is allowed.
// - ac select bit 7 picks line-based inversion when clear, frame-pair when set.
// - frame-pair mode gives an ac period of two frames.
// - line mode toggles ac polarity after every 16 scanned lines.
// - memory configuration write resets timing, disables display, may end power save.
// - origin offset control clear enables the offset, set disables it.
module lcg_char_config import lcg_pkg::*; #(
  parameter int AC_LINE_GROUP = AC_LINES
) (
  // clock and reset
  input wire logic CLK,
  input wire logic RESET,
  // register port
  input wire logic [7:0] REG_INDEX,
  input wire logic [7:0] REG_WDATA,
  input wire logic REG_WR,
  input wire logic REG_RD,
  output logic [7:0] REG_RDATA,
  // system events
  input wire logic INDIRECT_MODE,
  input wire logic POWER_SAVE_REQ,
  input wire logic DISPLAY_ON_REQ,
  input wire logic LINE_STROBE,
  input wire logic FRAME_STROBE,
  input wire logic [1:0] BPP_REQ,
  // configuration state
  output logic TIMING_RESET,
  output logic DISPLAY_ON,
  output logic POWER_SAVE,
  output logic AC_DRIVE,
  output logic [1:0] BPP_OUT,
  output logic PANEL_DUAL,
  output logic [4:0] GLYPH_HEIGHT,
  output logic [4:0] GLYPH_WIDTH,
  // glyph request
  input wire logic GLYPH_REQ,
  input wire logic [7:0] CHAR_CODE,
  input wire logic [3:0] GLYPH_ROW,
  input wire logic GLYPH_SEG,
  input wire logic GLYPH_LAYER,
  input wire logic GRAPHICS_MODE,
  // user glyph ram
  output logic RAM_RD,
  output logic [15:0] RAM_ADDR,
  input wire logic [7:0] RAM_DATA,
  // pixel output
  output logic PIX_VALID,
  output logic [7:0] PIX_BYTE,
  output logic PIX_LAYER
);
  if (AC_LINE_GROUP < 2) begin : g_bad_group
    $error("lcg_char_config: AC_LINE_GROUP must be at least 2");
  end

  logic [7:0] memcfg;
  logic [7:0] width_ac;
  logic [7:0] cg_lo;
  logic [7:0] cg_hi;
  logic wr_memcfg;
  logic ram_region_used;
  lcg_cfg_s cfg;
  lcg_req_s req;
  logic [7:0] rd_value;

  // glyph map results
  logic map_use_ram;
  logic [15:0] map_addr;
  logic [7:0] map_rom;
  logic map_row_ok;
  logic [7:0] map_mask;

  // first pipeline stage
  logic s1_valid;
  logic s1_use_ram;
  logic s1_row_ok;
  logic s1_layer;
  logic [7:0] s1_rom;
  logic [7:0] s1_mask;

  assign wr_memcfg = REG_WR && REG_INDEX == IDX_MEMCFG;

  always_comb begin
    cfg.origin_comp_off = memcfg[B_ORG];
    cfg.glyph_height_select = memcfg[B_TALL];
    cfg.glyph_source_select = memcfg[B_SRC];
    cfg.ac_inversion_select = width_ac[B_AC];
    cfg.glyph_width_m1 = width_ac[W_LSB +: W_BITS];
    cfg.cg_start = {cg_hi, cg_lo};
    req.code = CHAR_CODE;
    req.row = GLYPH_ROW;
    req.seg = GLYPH_SEG;
    req.layer = GLYPH_LAYER;
    req.graphics = GRAPHICS_MODE;
  end

  // configuration storage; unimplemented bits never stored
  always_ff @(posedge CLK) begin
    if (RESET) begin
      memcfg <= MEMCFG_RESET;
    end else if (wr_memcfg) begin
      memcfg <= REG_WDATA & MEMCFG_MASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      width_ac <= WIDTH_AC_RESET;
    end else if (REG_WR && REG_INDEX == IDX_WIDTH_AC) begin
      width_ac <= REG_WDATA & WIDTH_AC_MASK;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      cg_lo <= CG_LO_RESET;
      cg_hi <= CG_HI_RESET;
    end else if (REG_WR && REG_INDEX == IDX_CG_LO) begin
      cg_lo <= REG_WDATA;
    end else if (REG_WR && REG_INDEX == IDX_CG_HI) begin
      cg_hi <= REG_WDATA;
    end
  end

  always_comb begin
    case (REG_INDEX)
      IDX_MEMCFG: rd_value = memcfg;
      IDX_WIDTH_AC: rd_value = width_ac;
      IDX_CG_LO: rd_value = cg_lo;
      IDX_CG_HI: rd_value = cg_hi;
      default: rd_value = 8'h00;
    endcase
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RD) begin
      REG_RDATA <= rd_value;
    end
  end

  // side effects of a memory configuration write
  always_ff @(posedge CLK) begin
    if (RESET) begin
      TIMING_RESET <= 1'b0;
    end else begin
      TIMING_RESET <= wr_memcfg;
    end
  end

  // a request arriving with the write wins, so it is not lost
  always_ff @(posedge CLK) begin
    if (RESET) begin
      DISPLAY_ON <= 1'b0;
    end else if (DISPLAY_ON_REQ) begin
      DISPLAY_ON <= 1'b1;
    end else if (wr_memcfg) begin
      DISPLAY_ON <= 1'b0;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      POWER_SAVE <= 1'b0;
    end else if (POWER_SAVE_REQ) begin
      POWER_SAVE <= 1'b1;
    end else if (wr_memcfg && INDIRECT_MODE) begin
      POWER_SAVE <= 1'b0;
    end
  end

  // any user glyph fetch marks ram in use until the next reconfiguration; a fetch in that cycle wins
  always_ff @(posedge CLK) begin
    if (RESET) begin
      ram_region_used <= 1'b0;
    end else begin
      ram_region_used <= (ram_region_used && !wr_memcfg) || (GLYPH_REQ && map_use_ram);
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      BPP_OUT <= BPP_1;
    end else begin
      BPP_OUT <= (cfg.glyph_source_select || ram_region_used) ? BPP_1 : BPP_REQ;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      PANEL_DUAL <= 1'b0;
      GLYPH_HEIGHT <= HEIGHT_SHORT;
      GLYPH_WIDTH <= 5'h01;
    end else begin
      PANEL_DUAL <= memcfg[B_DUAL];
      GLYPH_HEIGHT <= cfg.glyph_height_select ? HEIGHT_TALL : HEIGHT_SHORT;
      GLYPH_WIDTH <= {1'b0, cfg.glyph_width_m1} + 5'h01;
    end
  end

  lcg_ac_drive #(
    .LINES(AC_LINE_GROUP)
  ) u_ac (
    .clk(CLK),
    .reset(RESET),
    .restart(TIMING_RESET),
    .frame_mode(cfg.ac_inversion_select),
    .line_stb(LINE_STROBE),
    .frame_stb(FRAME_STROBE),
    .ac(AC_DRIVE)
  );

  lcg_glyph_map u_map (
    .cfg(cfg),
    .req(req),
    .use_ram(map_use_ram),
    .ram_addr(map_addr),
    .rom_bits(map_rom),
    .row_ok(map_row_ok),
    .mask(map_mask)
  );

  // stage one: issue the user ram read, hold fixed glyph bits
  always_ff @(posedge CLK) begin
    if (RESET) begin
      s1_valid <= 1'b0;
      RAM_RD <= 1'b0;
    end else begin
      s1_valid <= GLYPH_REQ;
      RAM_RD <= GLYPH_REQ && map_use_ram && map_row_ok;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      RAM_ADDR <= 16'h0000;
      s1_use_ram <= 1'b0;
      s1_row_ok <= 1'b0;
      s1_layer <= 1'b0;
      s1_rom <= 8'h00;
      s1_mask <= 8'h00;
    end else if (GLYPH_REQ) begin
      RAM_ADDR <= map_addr;
      s1_use_ram <= map_use_ram;
      s1_row_ok <= map_row_ok;
      s1_layer <= GLYPH_LAYER;
      s1_rom <= map_rom;
      s1_mask <= map_mask;
    end
  end

  // stage two: ram data is sampled in the same cycle that the read strobe is high
  always_ff @(posedge CLK) begin
    if (RESET) begin
      PIX_VALID <= 1'b0;
      PIX_BYTE <= 8'h00;
      PIX_LAYER <= 1'b0;
    end else begin
      PIX_VALID <= s1_valid;
      PIX_LAYER <= s1_layer;
      if (s1_valid) begin
        PIX_BYTE <= (s1_use_ram ? RAM_DATA : s1_rom) & s1_mask & {8{s1_row_ok}};
      end
    end
  end

  property p_reserved_reset;
    @(posedge CLK) $past(RESET) |-> (memcfg == MEMCFG_RESET && !memcfg[B_RSV1]);
  endproperty
  a_reserved_reset: assert property (p_reserved_reset) else $error("memcfg reset value wrong");
  // a back to back write legally restarts the pulse
  property p_write_effects;
    @(posedge CLK) disable iff (RESET)
    (wr_memcfg && !DISPLAY_ON_REQ) |=> (TIMING_RESET && !DISPLAY_ON) ##1 (TIMING_RESET == $past(wr_memcfg));
  endproperty
  a_write_effects: assert property (p_write_effects) else $error("memcfg write side effects missing");
  property p_power_exit;
    @(posedge CLK) disable iff (RESET)
    (wr_memcfg && INDIRECT_MODE && !POWER_SAVE_REQ) |=> !POWER_SAVE;
  endproperty
  a_power_exit: assert property (p_power_exit) else $error("power save not ended");
  property p_readback;
    @(posedge CLK) disable iff (RESET)
    (REG_WR && REG_INDEX == IDX_WIDTH_AC) ##1 !REG_WR ##1 (REG_RD && !REG_WR && REG_INDEX == IDX_WIDTH_AC)
    |=> REG_RDATA == ($past(REG_WDATA, 3) & WIDTH_AC_MASK);
  endproperty
  a_readback: assert property (p_readback) else $error("register readback mismatch");
  property p_short_height;
    @(posedge CLK) disable iff (RESET)
    (GLYPH_REQ && cfg.glyph_source_select && !cfg.glyph_height_select && GLYPH_ROW >= 4'h9)
    |-> ##2 (PIX_VALID && PIX_BYTE == 8'h00);
  endproperty
  a_short_height: assert property (p_short_height) else $error("row beyond short height shown");
  property p_origin_row;
    @(posedge CLK) disable iff (RESET)
    (GLYPH_REQ && !cfg.origin_comp_off && GLYPH_ROW == 4'h0) |-> ##2 (PIX_BYTE == 8'h00);
  endproperty
  a_origin_row: assert property (p_origin_row) else $error("top row not blank under offset");
  property p_graphics_field;
    @(posedge CLK) disable iff (RESET)
    (GLYPH_REQ && GRAPHICS_MODE && GLYPH_SEG) |-> ##2 (PIX_BYTE == 8'h00);
  endproperty
  a_graphics_field: assert property (p_graphics_field) else $error("graphics excess width shown");
  property p_second_seg;
    @(posedge CLK) disable iff (RESET)
    (GLYPH_REQ && !GRAPHICS_MODE && GLYPH_SEG && cfg.glyph_width_m1 == 4'h8)
    |-> ##2 (PIX_BYTE[6:0] == 7'h00);
  endproperty
  a_second_seg: assert property (p_second_seg) else $error("pixels past width shown");
  property p_ram_source;
    @(posedge CLK) disable iff (RESET)
    (GLYPH_REQ && cfg.glyph_source_select && map_row_ok) |=> (RAM_RD && RAM_ADDR == $past(map_addr));
  endproperty
  a_ram_source: assert property (p_ram_source) else $error("user ram not read");
  property p_rom_limit;
    @(posedge CLK) disable iff (RESET)
    (GLYPH_REQ && !cfg.glyph_source_select && CHAR_CODE >= 8'hE0) |=> !RAM_RD ##1 (PIX_BYTE == 8'h00);
  endproperty
  a_rom_limit: assert property (p_rom_limit) else $error("ram glyph beyond limit used");
  property p_one_bpp;
    @(posedge CLK) disable iff (RESET)
    cfg.glyph_source_select |=> (BPP_OUT == BPP_1);
  endproperty
  a_one_bpp: assert property (p_one_bpp) else $error("depth not forced to 1 bpp");
endmodule : lcg_char_config

//--- rtl/lcg_glyph_map.sv
`timescale 1ns/1ps
module lcg_glyph_map import lcg_pkg::*; (
  // configuration and request
  input wire lcg_cfg_s cfg,
  input wire lcg_req_s req,
  // results
  output logic use_ram,
  output logic [15:0] ram_addr,
  output logic [7:0] rom_bits,
  output logic row_ok,
  output logic [7:0] mask
);
  function automatic logic [7:0] msb_mask(input logic [4:0] n);
    return (n >= SEG_PIX) ? 8'hFF : ~(8'hFF >> n);
  endfunction : msb_mask

  // fixed pattern standing in for the mask-programmed glyph set
  function automatic logic [4:0] rom_row(input logic [7:0] code, input logic [3:0] row);
    return code[4:0] ^ {row, 1'b1} ^ {2'h0, code[7:5]};
  endfunction : rom_row

  logic origin_on;
  logic top_blank;
  logic is_rom;
  logic ram_ok;
  logic tall_ram;
  logic [3:0] eff_row;
  logic [7:0] slot;
  logic [4:0] row_lim;
  logic [4:0] width;
  logic [4:0] seg_pix;

  always_comb begin
    origin_on = !cfg.origin_comp_off;
    eff_row = origin_on ? req.row - 4'h1 : req.row;
    top_blank = origin_on && req.row == 4'h0;
    is_rom = !cfg.glyph_source_select && req.code < ROM_CHARS;
    slot = cfg.glyph_source_select ? req.code : req.code - ROM_CHARS;
    ram_ok = cfg.glyph_source_select || (!is_rom && slot < RAM_CHARS_WITH_ROM);
    tall_ram = cfg.glyph_source_select && cfg.glyph_height_select;
    row_lim = is_rom ? ROM_ROWS : (tall_ram ? HEIGHT_TALL : HEIGHT_SHORT);
    row_ok = !top_blank && {1'b0, eff_row} < row_lim && (is_rom || ram_ok);
    use_ram = !is_rom && ram_ok;
    ram_addr = cfg.cg_start + (tall_ram ? {4'h0, slot, 4'h0} : {5'h00, slot, 3'h0})
               + {12'h000, eff_row};
    rom_bits = {rom_row(req.code, eff_row), 3'h0};
    // graphics mode always uses an eight pixel field
    width = req.graphics ? SEG_PIX : {1'b0, cfg.glyph_width_m1} + 5'h01;
    if (req.seg) begin
      seg_pix = (width > SEG_PIX) ? width - SEG_PIX : 5'h00;
    end else begin
      seg_pix = (width > SEG_PIX) ? SEG_PIX : width;
    end
    mask = msb_mask(seg_pix);
  end
endmodule : lcg_glyph_map

//--- testbench/lcg_char_config_bench.sv
`timescale 1ns/1ps
module lcg_char_config_bench import lcg_pkg::*; ;
  logic clk, reset, reg_wr, reg_rd, ind, ps_req, don_req, line_stb, frame_stb;
  logic greq, seg, layer, gfx, tr, don, ps, ac, dual, ram_rd, pv, pl;
  logic [7:0] idx, wdata, rdata, code, ram_data, pix;
  logic [3:0] row;
  logic [1:0] bpp_req, bpp_out;
  logic [4:0] gh, gw;
  logic [15:0] ram_addr;
  int bad_count = 0;
  int checked = 0;

  // short line group keeps the ac test brief
  lcg_char_config #(.AC_LINE_GROUP(4)) dut_u (
    .CLK(clk), .RESET(reset), .REG_INDEX(idx), .REG_WDATA(wdata), .REG_WR(reg_wr),
    .REG_RD(reg_rd), .REG_RDATA(rdata), .INDIRECT_MODE(ind), .POWER_SAVE_REQ(ps_req),
    .DISPLAY_ON_REQ(don_req), .LINE_STROBE(line_stb), .FRAME_STROBE(frame_stb),
    .BPP_REQ(bpp_req), .TIMING_RESET(tr), .DISPLAY_ON(don), .POWER_SAVE(ps),
    .AC_DRIVE(ac), .BPP_OUT(bpp_out), .PANEL_DUAL(dual), .GLYPH_HEIGHT(gh),
    .GLYPH_WIDTH(gw), .GLYPH_REQ(greq), .CHAR_CODE(code), .GLYPH_ROW(row),
    .GLYPH_SEG(seg), .GLYPH_LAYER(layer), .GRAPHICS_MODE(gfx), .RAM_RD(ram_rd),
    .RAM_ADDR(ram_addr), .RAM_DATA(ram_data), .PIX_VALID(pv), .PIX_BYTE(pix),
    .PIX_LAYER(pl)
  );
  lcg_glyph_ram_model ram_u (.clk(clk), .ram_rd(ram_rd), .ram_addr(ram_addr), .ram_data(ram_data));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [7:0] i, input logic [7:0] d);
    @(negedge clk);
    idx = i;
    wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask : wr

  task automatic rd_chk(input logic [7:0] i, input logic [7:0] e);
    @(negedge clk);
    idx = i;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(rdata, e);
  endtask : rd_chk

  task automatic strobe(input logic f);
    @(negedge clk);
    frame_stb = f;
    line_stb = ~f;
    @(negedge clk);
    frame_stb = 1'b0;
    line_stb = 1'b0;
    @(negedge clk);
  endtask : strobe

  // erd: 0 no fetch, 1 fetch at ea, 2 fetch not judged
  task automatic glyph(input logic [7:0] c, input logic [3:0] r, input logic s, input logic l,
                       input logic g, input logic [1:0] erd, input logic [15:0] ea, input logic [7:0] eb);
    @(negedge clk);
    greq = 1'b1;
    code = c;
    row = r;
    seg = s;
    layer = l;
    gfx = g;
    @(negedge clk);
    greq = 1'b0;
    if (erd != 2'h2) chk(ram_rd, erd[0]);
    if (erd == 2'h1) chk(ram_addr, ea);
    @(negedge clk);
    chk(pv, 1'h1);
    chk(pix, eb);
    chk(pl, l);
  endtask : glyph

  task automatic t_reset;
    rd_chk(IDX_MEMCFG, MEMCFG_RESET);
    rd_chk(IDX_WIDTH_AC, WIDTH_AC_RESET);
    rd_chk(IDX_CG_LO, 8'h00);
    rd_chk(IDX_CG_HI, 8'h00);
    chk(gh, 16'h0008);
    chk(gw, 16'h0001);
  endtask : t_reset

  task automatic t_regs;
    ind = 1'b1;
    @(negedge clk);
    don_req = 1'b1;
    ps_req = 1'b1;
    @(negedge clk);
    don_req = 1'b0;
    ps_req = 1'b0;
    @(negedge clk);
    wr(IDX_MEMCFG, 8'hFF);
    chk(tr, 1'h1);
    chk(don, 1'h0);
    chk(ps, 1'h0);
    @(negedge clk);
    chk(tr, 1'h0);
    chk(dual, 1'h1);
    ind = 1'b0;
    ps_req = 1'b1;
    @(negedge clk);
    ps_req = 1'b0;
    wr(IDX_MEMCFG, 8'h3F);
    chk(ps, 1'h1);
    rd_chk(IDX_MEMCFG, 8'h3F);
    wr(IDX_WIDTH_AC, 8'hFF);
    rd_chk(IDX_WIDTH_AC, 8'h8F);
    wr(8'h05, 8'hFF);
    rd_chk(8'h05, 8'h00);
    for (int w = 0; w < 16; w++) begin
      wr(IDX_WIDTH_AC, 8'(w));
      @(negedge clk);
      chk(gw, 16'(w + 1));
    end
    wr(IDX_MEMCFG, 8'h24);
    @(negedge clk);
    chk(gh, 16'h0010);
  endtask : t_regs

  task automatic t_ac;
    wr(IDX_WIDTH_AC, 8'h07);
    wr(IDX_MEMCFG, 8'h20);
    repeat (3) strobe(1'b0);
    chk(ac, 1'h0);
    strobe(1'b0);
    chk(ac, 1'h1);
    wr(IDX_WIDTH_AC, 8'h87);
    wr(IDX_MEMCFG, 8'h20);
    @(negedge clk);
    chk(ac, 1'h0);
    repeat (4) strobe(1'b0);
    chk(ac, 1'h0);
    strobe(1'b1);
    chk(ac, 1'h1);
    strobe(1'b1);
    chk(ac, 1'h0);
  endtask : t_ac

  task automatic t_ram;
    bpp_req = 2'h2;
    wr(IDX_CG_LO, 8'h34);
    wr(IDX_CG_HI, 8'h12);
    rd_chk(IDX_CG_HI, 8'h12);
    wr(IDX_WIDTH_AC, 8'h07);
    wr(IDX_MEMCFG, 8'h20);
    repeat (2) @(negedge clk);
    chk(bpp_out, 2'h2);
    wr(IDX_MEMCFG, 8'h21);
    glyph(8'h03, 4'h2, 1'b0, 1'b0, 1'b0, 2'h1, 16'h124E, 8'hEB);
    chk(bpp_out, 2'h0);
    glyph(8'h03, 4'h9, 1'b0, 1'b0, 1'b0, 2'h0, 16'h0000, 8'h00);
    wr(IDX_MEMCFG, 8'h25);
    glyph(8'h03, 4'h9, 1'b0, 1'b0, 1'b0, 2'h1, 16'h126D, 8'hC8);
    wr(IDX_MEMCFG, 8'h01);
    glyph(8'h03, 4'h0, 1'b0, 1'b0, 1'b0, 2'h0, 16'h0000, 8'h00);
    glyph(8'h03, 4'h3, 1'b0, 1'b0, 1'b0, 2'h1, 16'h124E, 8'hEB);
    // one extra block line brings the shifted bottom row back
    glyph(8'h03, 4'h8, 1'b0, 1'b0, 1'b0, 2'h1, 16'h1253, 8'hF6);
  endtask : t_ram

  task automatic t_width;
    wr(IDX_MEMCFG, 8'h21);
    wr(IDX_WIDTH_AC, 8'h0B);
    glyph(8'h03, 4'h2, 1'b0, 1'b0, 1'b0, 2'h1, 16'h124E, 8'hEB);
    glyph(8'h03, 4'h2, 1'b1, 1'b0, 1'b0, 2'h1, 16'h124E, 8'hE0);
    glyph(8'h03, 4'h2, 1'b1, 1'b1, 1'b0, 2'h1, 16'h124E, 8'hE0);
    glyph(8'h03, 4'h2, 1'b1, 1'b0, 1'b1, 2'h2, 16'h0000, 8'h00);
    glyph(8'h03, 4'h2, 1'b0, 1'b0, 1'b1, 2'h2, 16'h0000, 8'hEB);
    // second bitmap portion of a wide character, placed in graphics mode
    glyph(8'h04, 4'h2, 1'b0, 1'b0, 1'b1, 2'h1, 16'h1256, 8'hF3);
    wr(IDX_WIDTH_AC, 8'h04);
    glyph(8'h03, 4'h2, 1'b0, 1'b0, 1'b0, 2'h1, 16'h124E, 8'hE8);
    wr(IDX_WIDTH_AC, 8'h08);
    glyph(8'h03, 4'h2, 1'b1, 1'b0, 1'b0, 2'h1, 16'h124E, 8'h80);
  endtask : t_width

  task automatic t_rom;
    wr(IDX_WIDTH_AC, 8'h07);
    wr(IDX_MEMCFG, 8'h20);
    glyph(8'hA0, 4'h2, 1'b0, 1'b0, 1'b0, 2'h1, 16'h1236, 8'h93);
    chk(bpp_out, 2'h0);
    glyph(8'hC8, 4'h2, 1'b0, 1'b0, 1'b0, 2'h1, 16'h1376, 8'hD3);
    glyph(8'hE0, 4'h2, 1'b0, 1'b0, 1'b0, 2'h0, 16'h0000, 8'h00);
    glyph(8'h05, 4'h7, 1'b0, 1'b0, 1'b0, 2'h0, 16'h0000, 8'h00);
  endtask : t_rom

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : give_verdict

  initial begin
    {reg_wr, reg_rd, ind, ps_req, don_req, line_stb, frame_stb, greq, seg, layer, gfx} = '0;
    {idx, wdata, code} = '0;
    row = 4'h0;
    bpp_req = 2'h0;
    reset = 1'b1;
    repeat (3) @(negedge clk);
    reset = 1'b0;
    t_reset();
    t_regs();
    t_ac();
    t_ram();
    t_width();
    t_rom();
    give_verdict();
  end

  // whole run is a few hundred cycles
  initial begin
    #100000;
    bad_count++;
    give_verdict();
  end
endmodule : lcg_char_config_bench

//--- testbench/lcg_glyph_ram_model.sv
`timescale 1ns/1ps
module lcg_glyph_ram_model import lcg_pkg::*; (
  // clock
  input wire logic clk,
  // user glyph ram side
  input wire logic ram_rd,
  input wire logic [15:0] ram_addr,
  output logic [7:0] ram_data
);
  // outside a read it shows the inverse, so a sample taken late is caught
  always_comb ram_data = ram_rd ? (ram_addr[7:0] ^ 8'hA5) : ~(ram_addr[7:0] ^ 8'hA5);
endmodule : lcg_glyph_ram_model
